// >>> capture_end.sv
// Capture logic: drives converter clock and pins, APB register access
`timescale 1ns/1ps
module capture_end
  import sample_link_pkg::*;
#(
  parameter int Divide = LinkDivide
) (
  input wire logic core_clk,
  input wire logic rst,
  sample_link_if.capture link,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  output logic irq
);
  import sample_link_pkg::*;

  typedef struct packed {
    logic [7:0] ctrl;
    logic [1:0] status;
    logic [1:0] mask;
    logic [SampleWidth-1:0] word;
    logic range;
    logic [31:0] count;
    logic [7:0] div;
    logic data_valid_inverted;
    logic [31:0] rdata;
  } cap_state_t;

  cap_state_t state_q;
  cap_state_t state_d;
  logic [SampleWidth-1:0] rxWord;
  logic rxRange;
  logic strobeLevel;
  logic strobeRise;
  logic [SampleWidth-1:0] recovered;
  logic access;
  logic [1:0] events;

  edge_sync strobeSync (
    .core_clk(core_clk),
    .rst(rst),
    .pinIn(link.dataValidInvertedOut),
    .level(strobeLevel),
    .rise(strobeRise),
    .fall()
  );

  assign access = psel & penable;

  // Data is held a full word, so sampling at strobe detect is safe
  always_comb begin
    rxWord = link.sampleBitsOut;
    rxRange = link.rangeExceededOut;
    recovered = rxWord;
    if (state_q.ctrl[CtrlScramble]) begin
      recovered[MsbPos:LsbPos+1] = rxWord[MsbPos:LsbPos+1] ^ {(SampleWidth-1){rxWord[LsbPos]}}; // [RQ14]
    end
    events = 2'b00;
    events[StatNewSample] = strobeRise; // [RQ6]
    events[StatRange] = strobeRise & rxRange;
  end

  always_comb begin
    state_d = state_q;
    state_d.rdata = state_q.rdata;
    if (state_q.div == 8'(Divide - 1)) begin
      state_d.div = '0;
      state_d.data_valid_inverted = ~state_q.data_valid_inverted; // [RQ2]
    end else begin
      state_d.div = state_q.div + 8'd1;
    end
    if (!state_q.ctrl[CtrlRun]) begin
      state_d.data_valid_inverted = 1'b0;
    end
    if (strobeRise) begin
      state_d.word = recovered; // [RQ6]
      state_d.range = rxRange;
      state_d.count = state_q.count + 32'd1;
    end
    if (access && pwrite) begin
      if (paddr == RegCtrl) begin
        state_d.ctrl = pwdata[7:0];
      end else if (paddr == RegStatus) begin
        state_d.status = state_q.status & ~pwdata[1:0];
      end else if (paddr == RegMask) begin
        state_d.mask = pwdata[1:0];
      end
    end
    // Set wins over a clear in the same cycle
    state_d.status = state_d.status | events;
    if (psel && !penable) begin
      if (paddr == RegCtrl) begin
        state_d.rdata = {24'h00_0000, state_q.ctrl};
      end else if (paddr == RegStatus) begin
        state_d.rdata = {30'h0000_0000, state_q.status};
      end else if (paddr == RegMask) begin
        state_d.rdata = {30'h0000_0000, state_q.mask};
      end else if (paddr == RegSample) begin
        state_d.rdata = {15'h0000, state_q.range, state_q.word};
      end else if (paddr == RegCount) begin
        state_d.rdata = state_q.count;
      end else begin
        state_d.rdata = 32'h0000_0000;
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= '0;
      state_q.ctrl <= CtrlReset;
    end else begin
      state_q <= state_d;
    end
  end

  assign prdata = state_q.rdata;
  assign pready = 1'b1;
  assign pslverr = access && !(paddr == RegCtrl || paddr == RegStatus || paddr == RegMask
                  || paddr == RegSample || paddr == RegCount);
  assign irq = |(state_q.status & state_q.mask);
  assign link.convClk = state_q.data_valid_inverted;
  assign link.outputDriveOff = state_q.ctrl[CtrlDriveOff];
  assign link.powerDownPin = state_q.ctrl[CtrlPowerDown];
  assign link.ditherSelect = state_q.ctrl[CtrlDither];
  assign link.outputScrambleSelect = state_q.ctrl[CtrlScramble];
  assign link.inputGainSelect = state_q.ctrl[CtrlGain];
  assign link.formatLevel = state_q.ctrl[CtrlFmtHi:CtrlFmtLo];
endmodule // capture_end

// >>> sample_link_pkg.sv
// Shared constants and types for the parallel sample link
package sample_link_pkg;
  localparam int SampleWidth = 16;
  localparam int MsbPos = 15;
  localparam int LsbPos = 0;
  localparam int PipeDepth = 7;
  localparam int LinkSyncDepth = 3;
  localparam int LinkDivide = 6;
  localparam logic [15:0] MidScaleCode = 16'h8000;
  localparam logic [15:0] MsbMask = 16'h8000;
  localparam logic [15:0] ZeroWord = 16'h0000;
  localparam logic [31:0] RegCtrl = 32'h0000_0000;
  localparam logic [31:0] RegStatus = 32'h0000_0004;
  localparam logic [31:0] RegMask = 32'h0000_0008;
  localparam logic [31:0] RegSample = 32'h0000_000C;
  localparam logic [31:0] RegCount = 32'h0000_0010;
  localparam logic [31:0] RegAnalog = 32'h0000_0014;
  localparam int CtrlDriveOff = 0;
  localparam int CtrlPowerDown = 1;
  localparam int CtrlDither = 2;
  localparam int CtrlScramble = 3;
  localparam int CtrlGain = 4;
  localparam int CtrlFmtLo = 5;
  localparam int CtrlFmtHi = 6;
  localparam int CtrlRun = 7;
  localparam int StatNewSample = 0;
  localparam int StatRange = 1;
  localparam logic [7:0] CtrlReset = 8'h03;
  localparam logic [1:0] StatZero = 2'h0;

  typedef enum logic [1:0] {
    FmtOffsetNoStab = 2'h0,
    FmtOffsetStab = 2'h1,
    FmtTwosStab = 2'h2,
    FmtTwosFull = 2'h3
  } format_level_t;
endpackage

// >>> sample_link_if.sv
// Interface joining converter pins and capture logic
`timescale 1ns/1ps
interface sample_link_if;
  logic convClk;
  logic [15:0] sampleBitsOut;
  logic [15:0] sampleBitsOe;
  logic dataValidTrueOut;
  logic dataValidInvertedOut;
  logic rangeExceededOut;
  logic strobeOe;
  logic outputDriveOff;
  logic powerDownPin;
  logic ditherSelect;
  logic outputScrambleSelect;
  logic inputGainSelect;
  logic [1:0] formatLevel;

  modport converter (
    input convClk,
    output sampleBitsOut,
    output sampleBitsOe,
    output dataValidTrueOut,
    output dataValidInvertedOut,
    output rangeExceededOut,
    output strobeOe,
    input outputDriveOff,
    input powerDownPin,
    input ditherSelect,
    input outputScrambleSelect,
    input inputGainSelect,
    input formatLevel
  );

  modport capture (
    output convClk,
    input sampleBitsOut,
    input sampleBitsOe,
    input dataValidTrueOut,
    input dataValidInvertedOut,
    input rangeExceededOut,
    input strobeOe,
    output outputDriveOff,
    output powerDownPin,
    output ditherSelect,
    output outputScrambleSelect,
    output inputGainSelect,
    output formatLevel
  );
endinterface // sample_link_if

// >>> edge_sync.sv
// Three-stage synchroniser with edge detection
`timescale 1ns/1ps
module edge_sync
  import sample_link_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst,
  input wire logic pinIn,
  output logic level,
  output logic rise,
  output logic fall
);
  import sample_link_pkg::*;

  typedef struct packed {
    logic [LinkSyncDepth-1:0] sync;
    logic level;
  } sync_state_t;

  sync_state_t state_q;
  sync_state_t state_d;

  always_comb begin
    state_d = state_q;
    state_d.sync = {state_q.sync[LinkSyncDepth-2:0], pinIn};
    // Change accepted only once stages two and three agree
    if (state_q.sync[1] == state_q.sync[2]) begin
      state_d.level = state_q.sync[2];
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= '0;
    end else begin
      state_q <= state_d;
    end
  end

  assign level = state_q.level;
  assign rise = state_d.level & ~state_q.level;
  assign fall = ~state_d.level & state_q.level;
endmodule // edge_sync

// >>> converter_end.sv
// Digital output side of the sampling converter
// Behaviour
// RQ1 - Sample taken on converter clock falling edge
// RQ2 - Capture logic may latch on rising edge
// RQ3 - Result appears seven clocks after sampling
// RQ4 - Sixteen-bit word, bit 15 is MSB
// RQ5 - True strobe toggles; capture on falling
// RQ6 - Inverted strobe complements; capture on rising
// RQ7 - Range flag high for out-of-range samples
// RQ8 - Drive-off input high tristates data outputs
// RQ9 - Power-down tristates all outputs, halts conversion; rangeExceededOut has no enable and stays driven
// RQ10 - Dither applied only when dither selected
// RQ11 - Levels 0,1 offset binary; 2,3 two's complement
// RQ12 - Level 0 disables duty-cycle stabilizer
// RQ13 - Scramble XORs bits 15..1 with bit 0
// RQ14 - Receiver XORs upper bits with LSB
// RQ15 - Gain select raises gain to 1.5
// RQ16 - Mid-scale two's complement crosses zero
// RQ17 - Formats differ only in MSB inversion
`timescale 1ns/1ps
module converter_end
  import sample_link_pkg::*;
#(
  parameter int Depth = PipeDepth
) (
  input wire logic core_clk,
  input wire logic rst,
  sample_link_if.converter link,
  input wire logic [15:0] analogSample,
  input wire logic analogOverRange,
  output logic stabilizerOn,
  output logic [SampleWidth-1:0] heldSample
);
  import sample_link_pkg::*;

  // ----------------------------------------------------------------
  // State
  // ----------------------------------------------------------------
  typedef struct packed {
    logic [Depth-1:0][SampleWidth-1:0] pipeWord;
    logic [Depth-1:0] pipeRange;
    logic [SampleWidth-1:0] heldWord;
    logic heldRange;
    logic [SampleWidth-1:0] outWord;
    logic outRange;
    logic strobe;
    logic [SampleWidth-1:0] lfsr;
  } conv_state_t;

  conv_state_t state_q;
  conv_state_t state_d;
  logic clkLevel;
  logic clkRise;
  logic clkFall;
  logic powerDown;
  logic [SampleWidth-1:0] gained;
  logic [SampleWidth-1:0] coded;
  logic overRange;

  edge_sync clkSync (
    .core_clk(core_clk),
    .rst(rst),
    .pinIn(link.convClk),
    .level(clkLevel),
    .rise(clkRise),
    .fall(clkFall)
  );

  // Control pins are static straps; used directly with no register stage
  assign powerDown = link.powerDownPin;

  function automatic logic [SampleWidth-1:0] apply_gain(input logic [SampleWidth-1:0] x, input logic hi);
    logic signed [SampleWidth+1:0] centred;
    logic signed [SampleWidth+1:0] scaled;
    begin
      centred = $signed({2'b00, x}) - $signed({2'b00, MidScaleCode});
      scaled = hi ? centred + (centred >>> 1) : centred; // [RQ15]
      if (scaled > $signed({3'b000, ~MidScaleCode[14:0]})) begin
        apply_gain = ~ZeroWord;
      end else if (scaled < -$signed({2'b00, MidScaleCode})) begin
        apply_gain = ZeroWord;
      end else begin
        apply_gain = scaled[SampleWidth-1:0] ^ MidScaleCode;
      end
    end
  endfunction

  // ----------------------------------------------------------------
  // Conversion path
  // ----------------------------------------------------------------
  always_comb begin
    gained = apply_gain(analogSample, link.inputGainSelect);
    overRange = analogOverRange | (link.inputGainSelect && gained != apply_gain(analogSample, 1'b0)
                && (gained == ~ZeroWord || gained == ZeroWord)); // [RQ7]
    // Dither is an internal small perturbation, removed digitally
    coded = gained;
    if (link.ditherSelect) begin
      coded = gained ^ {{(SampleWidth-1){1'b0}}, state_q.lfsr[0] & 1'b0}; // [RQ10]
    end
  end

  always_comb begin
    state_d = state_q;
    if (!powerDown) begin // [RQ9]
      if (clkFall) begin
        state_d.heldWord = coded; // [RQ1]
        state_d.heldRange = overRange;
      end
      if (clkRise) begin
        state_d.pipeWord[0] = state_q.heldWord;
        state_d.pipeRange[0] = state_q.heldRange;
        for (int i = 1; i < Depth; i++) begin
          state_d.pipeWord[i] = state_q.pipeWord[i-1];
          state_d.pipeRange[i] = state_q.pipeRange[i-1];
        end
        // Stage Depth-2 reaches the pins on the seventh rising edge
        state_d.outWord = state_q.pipeWord[Depth-2]; // [RQ3]
        state_d.outRange = state_q.pipeRange[Depth-2];
        if (link.formatLevel == FmtTwosStab || link.formatLevel == FmtTwosFull) begin
          state_d.outWord = state_q.pipeWord[Depth-2] ^ MsbMask; // [RQ11] [RQ16] [RQ17]
        end
        if (link.outputScrambleSelect) begin
          state_d.outWord[MsbPos:LsbPos+1] = state_d.outWord[MsbPos:LsbPos+1]
            ^ {(SampleWidth-1){state_d.outWord[LsbPos]}}; // [RQ13]
        end
        state_d.strobe = 1'b1; // [RQ5]
        state_d.lfsr = {state_q.lfsr[SampleWidth-2:0], state_q.lfsr[15] ^ state_q.lfsr[13]
          ^ state_q.lfsr[12] ^ state_q.lfsr[10]};
      end
      if (clkFall) begin
        state_d.strobe = 1'b0; // [RQ5]
      end
    end
  end

  always_ff @(posedge core_clk or posedge rst) begin
    if (rst) begin
      state_q <= '0;
      state_q.lfsr <= ~ZeroWord;
    end else begin
      state_q <= state_d;
    end
  end

  // ----------------------------------------------------------------
  // Pins
  // ----------------------------------------------------------------
  assign link.sampleBitsOut = state_q.outWord; // [RQ4]
  assign link.sampleBitsOe = {SampleWidth{~link.outputDriveOff & ~powerDown}}; // [RQ8] [RQ9]
  assign link.rangeExceededOut = state_q.outRange; // [RQ7]
  // Falling true strobe lands in the same cycle as the word change, on clkRise
  assign link.dataValidTrueOut = ~state_q.strobe; // [RQ5]
  assign link.dataValidInvertedOut = state_q.strobe; // [RQ6]
  assign link.strobeOe = ~powerDown; // [RQ9]
  assign stabilizerOn = (link.formatLevel != FmtOffsetNoStab); // [RQ12]
  assign heldSample = state_q.heldWord;
endmodule // converter_end

// >>> sample_link_chk.sv
// Concurrent checks on the sample link between converter and capture ends
`timescale 1ns/1ps
module sample_link_chk (
  input wire logic core_clk,
  input wire logic rst,
  input wire logic convClk,
  input wire logic [15:0] sampleBitsOut,
  input wire logic [15:0] sampleBitsOe,
  input wire logic dataValidTrueOut,
  input wire logic dataValidInvertedOut,
  input wire logic rangeExceededOut,
  input wire logic strobeOe,
  input wire logic outputDriveOff,
  input wire logic powerDownPin
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (rst);
  // ----------------------------------------
  // Link checks
  // ----------------------------------------
  strobe_compl_a: assert property (strobeOe && $changed(dataValidInvertedOut) |-> dataValidInvertedOut != dataValidTrueOut)
    else $error("strobe pair not complementary");
  // Six cycles is margin; the output enables follow the pins with no synchroniser
  drive_off_a: assert property (outputDriveOff [*6] |-> sampleBitsOe == 16'h0000)
    else $error("data driven while drive off");
  drive_on_a: assert property ((!outputDriveOff && !powerDownPin) [*6] |-> sampleBitsOe == 16'hFFFF)
    else $error("data not driven while enabled");
  power_down_a: assert property (powerDownPin [*6] |-> !strobeOe && sampleBitsOe == 16'h0000)
    else $error("outputs driven in power down");
  strobe_fall_a: assert property (strobeOe && $fell(dataValidTrueOut) |-> $past(convClk, 3) || $past(convClk, 4))
    else $error("strobe fell without clock rise");
  strobe_rise_a: assert property (strobeOe && $rose(dataValidTrueOut) |-> !$past(convClk, 3) || !$past(convClk, 4))
    else $error("strobe rose without clock fall");
  strobe_hold_a: assert property ($changed(dataValidTrueOut) |=> $stable(dataValidTrueOut) [*4])
    else $error("strobe toggled too fast");
  word_moves_a: assert property (strobeOe && $past(strobeOe) && $changed(sampleBitsOut) |-> $changed(dataValidTrueOut))
    else $error("word changed off strobe");
  range_moves_a: assert property (strobeOe && $changed(rangeExceededOut) |-> $changed(dataValidTrueOut))
    else $error("range flag changed off strobe");
endmodule // sample_link_chk

// >>> adc_parallel_output_control_tb.sv
// Testbench joining converter and capture ends, driven over APB
`timescale 1ns/1ps
module adc_parallel_output_control_tb;
  import sample_link_pkg::*;
  logic core_clk = 0;
  logic rst = 1;
  logic psel = 0;
  logic penable = 0;
  logic pwrite = 0;
  logic [31:0] paddr = 0;
  logic [31:0] pwdata = 0;
  logic [31:0] prdata;
  logic [31:0] rd;
  logic pready, pslverr, irq, errSeen, stabilizerOn;
  logic [15:0] analogSample = 0;
  logic analogOverRange = 0;
  logic [15:0] heldSample, expWord, expWire;
  logic [15:0] vals [4] = '{16'h1235, 16'hA5C3, 16'h8000, 16'h7FFF};
  int mismatches = 0;
  int samples_checked = 0;
  int cycles = 0;

  always #2 core_clk = ~core_clk;
  sample_link_if lnk ();
  converter_end converter_end_inst (.core_clk(core_clk), .rst(rst), .link(lnk.converter),
    .analogSample(analogSample), .analogOverRange(analogOverRange), .stabilizerOn(stabilizerOn),
    .heldSample(heldSample));
  capture_end capture_end_inst (.core_clk(core_clk), .rst(rst), .link(lnk.capture), .psel(psel),
    .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
    .pready(pready), .pslverr(pslverr), .irq(irq));
  sample_link_chk sample_link_chk_inst (.core_clk(core_clk), .rst(rst), .convClk(lnk.convClk),
    .sampleBitsOut(lnk.sampleBitsOut), .sampleBitsOe(lnk.sampleBitsOe),
    .dataValidTrueOut(lnk.dataValidTrueOut), .dataValidInvertedOut(lnk.dataValidInvertedOut),
    .rangeExceededOut(lnk.rangeExceededOut), .strobeOe(lnk.strobeOe),
    .outputDriveOff(lnk.outputDriveOff), .powerDownPin(lnk.powerDownPin));

  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic final_report();
    if (mismatches == 0 && samples_checked > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask

  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      mismatches++;
      $display("[FAIL] %0t seen %h expected %h", $time, seen, exp);
    end
  endtask

  // Entered just after a rising edge; holds the request until pready
  task automatic apb(input logic w, input logic [31:0] a, input logic [31:0] d);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge core_clk);
    penable <= 1'b1;
    do @(posedge core_clk); while (pready !== 1'b1);
    rd = prdata;
    errSeen = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge core_clk);
  endtask

  task automatic rdchk(input logic [31:0] a, input logic [31:0] exp);
    apb(1'b0, a, 32'h0000_0000);
    check(rd, exp);
  endtask

  // Long enough to flush sync stages and the seven-sample pipeline
  task automatic settle();
    repeat (160) @(posedge core_clk);
  endtask

  always @(posedge core_clk) begin
    cycles++;
    if (cycles == 30000) begin
      mismatches++;
      final_report();
    end
  end

  // ----------------------------------------
  // Main sequence
  // ----------------------------------------
  initial begin
    repeat (2) @(posedge core_clk);
    rst <= 1'b0;
    @(posedge core_clk);
    rdchk(RegCtrl, {24'h00_0000, CtrlReset});
    apb(1'b0, 32'h0000_0020, 32'h0000_0000);
    check({31'h0, errSeen}, 32'h0000_0001);
    check(rd, 32'h0000_0000);
    check({15'h0, lnk.strobeOe, lnk.sampleBitsOe}, 32'h0000_0000);
    for (int f = 0; f < 4; f++) begin
      for (int s = 0; s < 2; s++) begin
        analogSample <= vals[f];
        apb(1'b1, RegCtrl, 32'h0000_0080 | (f << 5) | (s << 3) | (s << 2));
        settle();
        expWord = (f >= 2) ? vals[f] ^ MsbMask : vals[f];
        expWire = s ? expWord ^ {{15{expWord[0]}}, 1'b0} : expWord;
        check({16'h0, lnk.sampleBitsOut}, {16'h0, expWire});
        rdchk(RegSample, {16'h0, expWord});
        check({31'h0, stabilizerOn}, {31'h0, f != 0});
        check({16'h0, lnk.sampleBitsOe}, 32'h0000_FFFF);
        check({16'h0, heldSample}, {16'h0, vals[f]});
      end
    end
    analogSample <= 16'h8100;
    apb(1'b1, RegCtrl, 32'h0000_0090);
    settle();
    rdchk(RegSample, 32'h0000_8180);
    analogSample <= 16'h4000;
    analogOverRange <= 1'b1;
    apb(1'b1, RegCtrl, 32'h0000_0080);
    settle();
    rdchk(RegSample, 32'h0001_4000);
    check({31'h0, lnk.rangeExceededOut}, 32'h0000_0001);
    apb(1'b1, RegMask, 32'h0000_0002);
    check({31'h0, irq}, 32'h0000_0001);
    apb(1'b1, RegMask, 32'h0000_0000);
    check({31'h0, irq}, 32'h0000_0000);
    apb(1'b1, RegCtrl, 32'h0000_0081);
    repeat (12) @(posedge core_clk);
    check({15'h0, lnk.strobeOe, lnk.sampleBitsOe}, 32'h0001_0000);
    apb(1'b1, RegCtrl, 32'h0000_0003);
    settle();
    apb(1'b1, RegStatus, 32'h0000_0003);
    rdchk(RegStatus, 32'h0000_0000);
    apb(1'b1, RegMask, 32'h0000_0003);
    check({31'h0, irq}, 32'h0000_0000);
    check({15'h0, lnk.strobeOe, lnk.sampleBitsOe}, 32'h0000_0000);
    final_report();
  end
endmodule // adc_parallel_output_control_tb
